// ---- verilog/acc_defs.svh ----
// Notes on behaviour
// - Writing one to the status bit starts a conversion; it reads one while converting.
// - Hardware clears the status bit when the conversion completes.
// - Enable bit one powers the converter; zero disables it with no operating current.
// - Channel codes 00000 to 01011 connect external analog inputs 0 to 11.
// - Channel codes 01100 to 11100 are reserved and connect no channel.
// - Channel code 11101 connects the temperature indicator.
// - Channel code 11110 connects the internal DAC output.
// - Channel code 11111 connects the fixed reference first buffer output.
// - Control bit 7 is unimplemented, reads zero and ignores writes.
// - All implemented control bits reset to zero on every reset.
// - Right-justified result: high register holds upper 2 bits, low register lower 8.
// - On completion clear status, set the done flag, load both result registers.
// - Early status clear stops conversion; unconverted result bits copy the last converted bit.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_ADDR_W       5
`define ACC_OFS_CONTROL  5'h00
`define ACC_OFS_RES_HIGH 5'h04
`define ACC_OFS_RES_LOW  5'h08
`define ACC_OFS_FLAGS    5'h0C
`define ACC_BIT_ON       0
`define ACC_BIT_GO       1
`define ACC_CHS_LSB      2
`define ACC_CHS_MSB      6
`define ACC_BIT_UNUSED   7
`define ACC_BIT_FLAG     0
`define ACC_CHS_LAST_EXT 5'h0B
`define ACC_CHS_TEMP     5'h1D
`define ACC_CHS_DAC      5'h1E
`define ACC_CHS_FVR      5'h1F
`define ACC_EXT_CHANNELS 12
`define ACC_CTRL_RESET   8'h00
`define ACC_RESULT_BITS  10
`define ACC_HIGH_BITS    2
`define ACC_LOW_BITS     8
`define ACC_RESP_OKAY    2'h0
`define ACC_RESP_SLVERR  2'h2
`define ACC_CLK_NS       25
`define ACC_TAD_NS       1000
`define ACC_TAD_CYCLES   ((`ACC_TAD_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_TAD_CNT_W    6
`define ACC_TAD_LAST     (6'(`ACC_TAD_CYCLES - 1))
`define ACC_MSB_IDX      4'h9
`endif

// ---- verilog/acc_pkg.sv ----
`default_nettype none
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_HOLD,
    ACC_CONVERT
  } acc_sar_state_type;
endpackage
`default_nettype wire

// ---- verilog/acc_sar_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_sar_engine import acc_pkg::*; (
  input  wire logic       clk_in,     // System clock.
  input  wire logic       rst_b_in,   // Asynchronous reset, active low.
  input  wire logic       start_in,   // Start pulse.
  input  wire logic       abort_in,   // Abort pulse.
  input  wire logic       comp_in,    // Comparator: input at or above trial.
  output logic            busy_out,   // Conversion in progress.
  output logic            done_out,   // One-cycle pulse, result loaded.
  output logic            hold_out,   // Hold capacitor disconnected from input.
  output logic [9:0]      result_out, // Last result.
  output logic [9:0]      trial_out   // Trial code for the comparator DAC.
);
  acc_sar_state_type state, next_state;
  logic [`ACC_TAD_CNT_W-1:0] tad, next_tad;
  logic [3:0]  idx, next_idx;
  logic [9:0]  sar, next_sar, mask, next_mask, next_result, next_trial, fill;
  logic        last, next_last, next_done, tad_end;

  assign busy_out = (state != ACC_IDLE);
  assign hold_out = (state != ACC_IDLE);

  always_comb begin
    tad_end     = (tad == `ACC_TAD_LAST);
    fill        = (sar & mask) | (last ? ~mask : 10'h000);
    next_state  = state;
    next_tad    = tad_end ? '0 : `ACC_TAD_CNT_W'(tad + 1'b1);
    next_idx    = idx;
    next_sar    = sar;
    next_mask   = mask;
    next_last   = last;
    next_done   = 1'b0;
    next_result = result_out;
    unique case (state)
      ACC_IDLE: begin
        next_tad = '0;
        if (start_in) begin
          next_state = ACC_HOLD;
          next_sar   = 10'h000;
          next_mask  = 10'h000;
          next_last  = 1'b0;
        end
      end
      ACC_HOLD: begin
        if (tad_end) begin
          next_state = ACC_CONVERT;
          next_idx   = `ACC_MSB_IDX;
        end
      end
      ACC_CONVERT: begin
        if (tad_end) begin
          next_sar[idx]  = comp_in;
          next_mask[idx] = 1'b1;
          next_last      = comp_in;
          if (idx == 4'h0) begin
            next_state  = ACC_IDLE;
            next_done   = 1'b1;
            next_result = next_sar;
          end else begin
            next_idx = 4'(idx - 4'h1);
          end
        end
      end
    endcase
    if (abort_in && state != ACC_IDLE) begin
      next_state  = ACC_IDLE;
      next_done   = 1'b1;
      next_result = fill;
    end
    next_trial = (next_state == ACC_CONVERT) ? (next_sar | 10'(10'h001 << next_idx)) : 10'h000;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= ACC_IDLE;
      tad        <= '0;
      idx        <= 4'h0;
      sar        <= 10'h000;
      mask       <= 10'h000;
      last       <= 1'b0;
      done_out   <= 1'b0;
      result_out <= 10'h000;
      trial_out  <= 10'h000;
    end else begin
      state      <= next_state;
      tad        <= next_tad;
      idx        <= next_idx;
      sar        <= next_sar;
      mask       <= next_mask;
      last       <= next_last;
      done_out   <= next_done;
      result_out <= next_result;
      trial_out  <= next_trial;
    end
  end

  sequence s_start;
    state == ACC_IDLE && start_in;
  endsequence
  property p_busy_runs;
    @(posedge clk_in) disable iff (!rst_b_in) s_start |=> (busy_out && !done_out) [*8];
  endproperty
  a_busy_runs: assert property (p_busy_runs) else $error("conversion did not stay busy");
  property p_done_clears;
    @(posedge clk_in) disable iff (!rst_b_in)
      (state == ACC_CONVERT && tad_end && idx == 4'h0) |=> (!busy_out && done_out);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("busy not cleared at completion");
  property p_abort_partial;
    @(posedge clk_in) disable iff (!rst_b_in)
      (abort_in && busy_out) |=> (!busy_out && done_out && result_out == $past(fill));
  endproperty
  a_abort_partial: assert property (p_abort_partial) else $error("abort result wrong");
endmodule
`default_nettype wire

// ---- verilog/acc_chan_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_chan_decode import acc_pkg::*; (
  input  wire logic        clk_in,      // System clock.
  input  wire logic        rst_b_in,    // Asynchronous reset, active low.
  input  wire logic        enable_in,   // Converter on.
  input  wire logic [4:0]  code_in,     // Channel selector.
  output logic [11:0]      ext_sel_out, // External input switches.
  output logic             temp_sel_out, // Temperature indicator switch.
  output logic             dac_sel_out, // Internal DAC switch.
  output logic             fvr_sel_out  // Fixed reference buffer switch.
);
  logic [11:0] next_ext;
  logic        next_temp, next_dac, next_fvr;

  // Switches open while off so the disabled converter loads no input.
  genvar g;
  for (g = 0; g < `ACC_EXT_CHANNELS; g++) begin : g_ext
    assign next_ext[g] = enable_in && (code_in == 5'(g));
  end

  always_comb begin
    next_temp = enable_in && (code_in == `ACC_CHS_TEMP);
    next_dac  = enable_in && (code_in == `ACC_CHS_DAC);
    next_fvr  = enable_in && (code_in == `ACC_CHS_FVR);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_sel_out  <= 12'h000;
      temp_sel_out <= 1'b0;
      dac_sel_out  <= 1'b0;
      fvr_sel_out  <= 1'b0;
    end else begin
      ext_sel_out  <= next_ext;
      temp_sel_out <= next_temp;
      dac_sel_out  <= next_dac;
      fvr_sel_out  <= next_fvr;
    end
  end

  property p_reserved;
    @(posedge clk_in) disable iff (!rst_b_in)
      (code_in > `ACC_CHS_LAST_EXT && code_in < `ACC_CHS_TEMP)
      |=> (ext_sel_out == 12'h000 && !temp_sel_out && !dac_sel_out && !fvr_sel_out);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code connected a channel");
  property p_ext;
    @(posedge clk_in) disable iff (!rst_b_in)
      (enable_in && code_in <= `ACC_CHS_LAST_EXT) |=> (ext_sel_out == 12'(12'h001 << $past(code_in)));
  endproperty
  a_ext: assert property (p_ext) else $error("wrong external channel");
  property p_internal;
    @(posedge clk_in) disable iff (!rst_b_in)
      enable_in |=> (temp_sel_out == ($past(code_in) == `ACC_CHS_TEMP)
                 && dac_sel_out == ($past(code_in) == `ACC_CHS_DAC)
                 && fvr_sel_out == ($past(code_in) == `ACC_CHS_FVR));
  endproperty
  a_internal: assert property (p_internal) else $error("internal source routing wrong");
endmodule
`default_nettype wire

// ---- verilog/acc_adc_ctrl.sv ----
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_adc_ctrl import acc_pkg::*; (
  input  wire logic                   ref_clk_in,          // System clock, 40 MHz.
  input  wire logic                   rst_b_in,            // Asynchronous reset, active low.
  input  wire logic [`ACC_ADDR_W-1:0] s_axi_awaddr_in,     // Write address.
  input  wire logic                   s_axi_awvalid_in,    // Write address valid.
  output logic                        s_axi_awready_out,   // Write address ready.
  input  wire logic [31:0]            s_axi_wdata_in,      // Write data.
  input  wire logic [3:0]             s_axi_wstrb_in,      // Write byte enables.
  input  wire logic                   s_axi_wvalid_in,     // Write data valid.
  output logic                        s_axi_wready_out,    // Write data ready.
  output logic [1:0]                  s_axi_bresp_out,     // Write response.
  output logic                        s_axi_bvalid_out,    // Write response valid.
  input  wire logic                   s_axi_bready_in,     // Write response ready.
  input  wire logic [`ACC_ADDR_W-1:0] s_axi_araddr_in,     // Read address.
  input  wire logic                   s_axi_arvalid_in,    // Read address valid.
  output logic                        s_axi_arready_out,   // Read address ready.
  output logic [31:0]                 s_axi_rdata_out,     // Read data.
  output logic [1:0]                  s_axi_rresp_out,     // Read response.
  output logic                        s_axi_rvalid_out,    // Read data valid.
  input  wire logic                   s_axi_rready_in,     // Read data ready.
  input  wire logic                   comp_in,             // Comparator decision.
  output logic [9:0]                  trial_code_out,      // Trial code to comparator DAC.
  output logic                        hold_out,            // Hold capacitor disconnected.
  output logic                        converter_on_out,    // Analog power enable.
  output logic [11:0]                 ext_channel_sel_out, // External input switches.
  output logic                        temp_sel_out,        // Temperature indicator switch.
  output logic                        dac_sel_out,         // Internal DAC switch.
  output logic                        fixed_reference_sel_out, // Fixed reference switch.
  output logic                        conversion_done_flag_out // Done flag level.
);
  logic                   converter_on, next_converter_on;
  logic [4:0]             channel_select, next_channel_select;
  logic                   conversion_done_flag, next_conversion_done_flag;
  logic                   bvalid, next_bvalid;
  logic [1:0]             bresp, next_bresp;
  logic                   rvalid, next_rvalid;
  logic [1:0]             rresp, next_rresp;
  logic [31:0]            rdata, next_rdata;
  logic [`ACC_ADDR_W-1:0] rd_addr, next_rd_addr;
  logic                   wr_fire, rd_fire, ctrl_wr, flag_wr, wr_mapped;
  logic                   start_req, abort_req;
  logic                   busy, eng_done;
  logic [9:0]             eng_result;
  localparam logic [7:0]  ctrl_reset_value = `ACC_CTRL_RESET;

  // Address and data are taken together so a write never waits half done.
  always_comb begin
    wr_fire   = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid;
    rd_fire   = s_axi_arvalid_in && !rvalid;
    wr_mapped = (s_axi_awaddr_in == `ACC_OFS_CONTROL) || (s_axi_awaddr_in == `ACC_OFS_RES_HIGH)
             || (s_axi_awaddr_in == `ACC_OFS_RES_LOW) || (s_axi_awaddr_in == `ACC_OFS_FLAGS);
    ctrl_wr   = wr_fire && s_axi_wstrb_in[0] && (s_axi_awaddr_in == `ACC_OFS_CONTROL);
    flag_wr   = wr_fire && s_axi_wstrb_in[0] && (s_axi_awaddr_in == `ACC_OFS_FLAGS);
    // The enable checked is the one already stored, so a write that both enables and
    // starts only enables; this keeps the analog side settled before a start.
    start_req = ctrl_wr && s_axi_wdata_in[`ACC_BIT_GO] && converter_on && !busy;
    abort_req = ctrl_wr && busy
             && (!s_axi_wdata_in[`ACC_BIT_GO] || !s_axi_wdata_in[`ACC_BIT_ON]);
  end

  assign s_axi_awready_out = wr_fire;
  assign s_axi_wready_out  = wr_fire;
  assign s_axi_arready_out = rd_fire;
  assign s_axi_bvalid_out  = bvalid;
  assign s_axi_bresp_out   = bresp;
  assign s_axi_rvalid_out  = rvalid;
  assign s_axi_rresp_out   = rresp;
  assign s_axi_rdata_out   = rdata;
  assign converter_on_out  = converter_on;
  assign conversion_done_flag_out = conversion_done_flag;

  always_comb begin
    next_converter_on         = converter_on;
    next_channel_select       = channel_select;
    next_conversion_done_flag = conversion_done_flag;
    if (ctrl_wr) begin
      next_converter_on   = s_axi_wdata_in[`ACC_BIT_ON];
      next_channel_select = s_axi_wdata_in[`ACC_CHS_MSB:`ACC_CHS_LSB];
    end
    if (flag_wr && s_axi_wdata_in[`ACC_BIT_FLAG]) begin
      next_conversion_done_flag = 1'b0;
    end
    // A completion in the same cycle as a clear keeps the flag set.
    if (eng_done) begin
      next_conversion_done_flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      converter_on         <= ctrl_reset_value[`ACC_BIT_ON];
      channel_select       <= ctrl_reset_value[`ACC_CHS_MSB:`ACC_CHS_LSB];
      conversion_done_flag <= 1'b0;
    end else begin
      converter_on         <= next_converter_on;
      channel_select       <= next_channel_select;
      conversion_done_flag <= next_conversion_done_flag;
    end
  end

  always_comb begin
    next_bvalid = bvalid;
    next_bresp  = bresp;
    if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end
  end

  always_comb begin
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_rd_addr = rd_addr;
    if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid  = 1'b1;
      next_rresp   = `ACC_RESP_OKAY;
      next_rd_addr = s_axi_araddr_in;
      unique case (s_axi_araddr_in)
        `ACC_OFS_CONTROL: begin
          next_rdata = {24'h000000, 1'b0, channel_select, busy, converter_on};
        end
        `ACC_OFS_RES_HIGH: begin
          next_rdata = {30'h00000000, eng_result[`ACC_RESULT_BITS-1 -: `ACC_HIGH_BITS]};
        end
        `ACC_OFS_RES_LOW: begin
          next_rdata = {24'h000000, eng_result[`ACC_LOW_BITS-1:0]};
        end
        `ACC_OFS_FLAGS: begin
          next_rdata = {31'h00000000, conversion_done_flag};
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `ACC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bvalid  <= 1'b0;
      bresp   <= `ACC_RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `ACC_RESP_OKAY;
      rdata   <= 32'h00000000;
      rd_addr <= `ACC_OFS_CONTROL;
    end else begin
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      rd_addr <= next_rd_addr;
    end
  end

  acc_sar_engine u_engine (
    .clk_in     (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .start_in   (start_req),
    .abort_in   (abort_req),
    .comp_in    (comp_in),
    .busy_out   (busy),
    .done_out   (eng_done),
    .hold_out   (hold_out),
    .result_out (eng_result),
    .trial_out  (trial_code_out)
  );

  acc_chan_decode u_decode (
    .clk_in       (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .enable_in    (converter_on),
    .code_in      (channel_select),
    .ext_sel_out  (ext_channel_sel_out),
    .temp_sel_out (temp_sel_out),
    .dac_sel_out  (dac_sel_out),
    .fvr_sel_out  (fixed_reference_sel_out)
  );

  sequence s_ctrl_read;
    rvalid && rd_addr == `ACC_OFS_CONTROL;
  endsequence
  sequence s_go_write;
    ctrl_wr && s_axi_wdata_in[`ACC_BIT_GO] && s_axi_wdata_in[`ACC_BIT_ON];
  endsequence

  property p_start;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (s_go_write and (converter_on && !busy)) |=> busy ##1 busy;
  endproperty
  a_start: assert property (p_start) else $error("start write did not begin conversion");

  property p_no_start_off;
    @(posedge ref_clk_in) disable iff (!rst_b_in) (!converter_on && !busy) |=> !busy;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("conversion began while disabled");

  property p_off_stops;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (ctrl_wr && !s_axi_wdata_in[`ACC_BIT_ON]) |=> (!converter_on_out && !busy);
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("disable left converter running");

  property p_done_flag;
    @(posedge ref_clk_in) disable iff (!rst_b_in) eng_done |=> (conversion_done_flag && !busy);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set on completion");

  property p_bit7;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_ctrl_read |-> (rdata[31:`ACC_BIT_UNUSED] == 25'h0000000);
  endproperty
  a_bit7: assert property (p_bit7) else $error("unimplemented control bit read as one");

  property p_result_split;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      (rd_fire && s_axi_araddr_in == `ACC_OFS_RES_HIGH && !eng_done)
      |=> (rdata == {30'h00000000, $past(eng_result[`ACC_RESULT_BITS-1 -: `ACC_HIGH_BITS])});
  endproperty
  a_result_split: assert property (p_result_split) else $error("high result register wrong");

  property p_go_clears;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      $fell(busy) |-> ##1 conversion_done_flag;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("status cleared without done flag");
endmodule
`default_nettype wire

// ---- tb/acc_adc_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "acc_defs.svh"
module acc_adc_ctrl_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic [4:0]  awaddr  = 5'h00;
  logic [4:0]  araddr  = 5'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        comp    = 1'b0;
  logic [9:0]  tgt     = 10'h000;
  logic [15:0] lf      = 16'hE797;
  wire  logic        awready, wready, bvalid, arready, rvalid;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  wire  logic [9:0]  trial;
  wire  logic        hold, on, temp, dac, fixed_reference, flag;
  wire  logic [11:0] ext;
  int          errors  = 0;
  int          checked = 0;

  acc_adc_ctrl acc_adc_ctrl_inst (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .comp_in(comp), .trial_code_out(trial), .hold_out(hold), .converter_on_out(on),
    .ext_channel_sel_out(ext), .temp_sel_out(temp), .dac_sel_out(dac),
    .fixed_reference_sel_out(fixed_reference), .conversion_done_flag_out(flag));

  always #12.5 ref_clk = ~ref_clk;

  // The comparator model answers from the trial code of the previous cycle, which is stable per bit period.
  always @(posedge ref_clk) begin
    comp <= (tgt >= trial);
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Bits not yet converted copy the last converted bit; none converted gives zero.
  function automatic logic [9:0] part(input logic [9:0] t, input int k);
    logic [9:0] r;
    for (int i = 9; i >= 0; i--) begin
      r[i] = (k <= 0) ? 1'b0 : (i >= 10 - k) ? t[i] : t[10 - k];
    end
    return r;
  endfunction

  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge ref_clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge ref_clk);
    chk(bresp, er);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge ref_clk);
    d = rdata;
    chk(rresp, er);
    rready <= 1'b0;
  endtask

  // A negative count runs to completion; otherwise abort after that many converted bits.
  task automatic conv(input int k);
    logic [31:0] d;
    logic [9:0]  ex;
    tgt <= lf[9:0];
    lf = nx(lf);
    wr(`ACC_OFS_CONTROL, 32'h3, `ACC_RESP_OKAY);
    rd(`ACC_OFS_CONTROL, d, `ACC_RESP_OKAY);
    chk(d, 32'h3);
    chk(hold, 1'b1);
    if (k >= 0) begin
      repeat (40 * (k + 1) + 20) @(posedge ref_clk);
      wr(`ACC_OFS_CONTROL, 32'h1, `ACC_RESP_OKAY);
    end
    d = 32'h3;
    while (d[1] === 1'b1) rd(`ACC_OFS_CONTROL, d, `ACC_RESP_OKAY);
    chk(d, 32'h1);
    ex = (k < 0) ? tgt : part(tgt, k);
    rd(`ACC_OFS_RES_HIGH, d, `ACC_RESP_OKAY);
    chk(d, {30'h0, ex[9:8]});
    rd(`ACC_OFS_RES_LOW, d, `ACC_RESP_OKAY);
    chk(d, {24'h0, ex[7:0]});
    rd(`ACC_OFS_FLAGS, d, `ACC_RESP_OKAY);
    chk(d, 32'h1);
    chk(flag, 1'b1);
    wr(`ACC_OFS_FLAGS, 32'h1, `ACC_RESP_OKAY);
    rd(`ACC_OFS_FLAGS, d, `ACC_RESP_OKAY);
    chk(d, 32'h0);
    chk(flag, 1'b0);
  endtask

  initial begin
    logic [31:0] d;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`ACC_OFS_CONTROL, d, `ACC_RESP_OKAY);
    chk(d, 32'h0);
    rd(`ACC_OFS_FLAGS, d, `ACC_RESP_OKAY);
    chk(d, 32'h0);
    wr(`ACC_OFS_CONTROL, 32'h82, `ACC_RESP_OKAY);
    rd(`ACC_OFS_CONTROL, d, `ACC_RESP_OKAY);
    chk(d, 32'h0);
    chk(hold, 1'b0);
    wr(`ACC_OFS_CONTROL, 32'h3, `ACC_RESP_OKAY);
    rd(`ACC_OFS_CONTROL, d, `ACC_RESP_OKAY);
    chk(d, 32'h1);
    chk(on, 1'b1);
    for (int c = 0; c < 32; c++) begin
      wr(`ACC_OFS_CONTROL, {25'h0, c[4:0], 2'b01}, `ACC_RESP_OKAY);
      @(posedge ref_clk);
      chk({ext, temp, dac, fixed_reference}, {(c < 12) ? 12'h001 << c : 12'h000, c == 29, c == 30, c == 31});
    end
    wr(`ACC_OFS_CONTROL, 32'h7C, `ACC_RESP_OKAY);
    @(posedge ref_clk);
    chk({on, ext, temp, dac, fixed_reference}, 32'h0);
    wr(`ACC_OFS_CONTROL, 32'h1, `ACC_RESP_OKAY);
    repeat (40) @(posedge ref_clk);
    conv(-1);
    conv(-1);
    conv(3);
    conv(0);
    rd(5'h10, d, `ACC_RESP_SLVERR);
    chk(d, 32'h0);
    wr(5'h14, 32'h1, `ACC_RESP_SLVERR);
    print_verdict();
  end

  initial begin
    #(25 * 20000);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
